// ### design/sync_serial_pkg.sv
/*
 * Constants, register map and carrier types for the clocked synchronous serial unit.
 * Assumes a 32-bit Avalon-MM slave port with word-aligned byte addresses.
 */
package sync_serial_pkg;
  localparam logic [5:0] ADDR_ROLE = 6'h00;
  localparam logic [5:0] ADDR_MODE = 6'h04;
  localparam logic [5:0] ADDR_ORDER_RATE = 6'h08;
  localparam logic [5:0] ADDR_DIR_EN = 6'h0c;
  localparam logic [5:0] ADDR_FLAGS = 6'h10;
  localparam logic [5:0] ADDR_RX_HOLD = 6'h14;
  localparam logic [5:0] ADDR_TX_HOLD = 6'h18;
  localparam logic [5:0] ADDR_CLK_HALT = 6'h1c;
  // field positions
  localparam int ROLE_MASTER_BIT = 6;
  localparam int ROLE_CLKPIN_BIT = 5;
  localparam int ORDER_BIT = 7;
  localparam int EN_TX_BIT = 7;
  localparam int EN_RX_BIT = 6;
  localparam int EN_SSTOP_BIT = 5;
  localparam int FLAG_OVERRUN_BIT = 6;
  localparam int FLAG_TX_EMPTY_BIT = 2;
  localparam int FLAG_TX_END_BIT = 3;
  localparam int FLAG_RX_FULL_BIT = 1;
  localparam int HALT_RELEASE_BIT = 0;
  localparam logic [1:0] MODE_CLOCKED_SYNC = 2'h1;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  // rate codes: divide by 4 << code; code 1 gives the divide-by-eight rate
  localparam logic [2:0] RATE_DIV8 = 3'h1;
  localparam int BITS_PER_BYTE = 8;

  typedef struct packed {
    logic master;
    logic clk_out_en;
    logic msb_first;
    logic [2:0] rate;
    logic tx_en;
    logic rx_en;
    logic single_stop;
    logic run;
  } unit_cfg_t;

  typedef struct packed {
    logic sck;
    logic sdi;
  } pin_in_t;
endpackage

// ### design/rate_divider.sv
/*
 * Half-period tick generator for the transfer clock.
 * Assumes the system clock; produces one-cycle enable pulses only.
 */
`timescale 1ns/1ps
module rate_divider import sync_serial_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  input wire logic [2:0] i_rate,
  output logic o_tick
);
  logic [9:0] cnt_ff;
  logic [9:0] half_w;
  // half period in system cycles: (4 << rate) / 2
  assign half_w = 10'(10'h002 << i_rate);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 10'h000;
      o_tick <= 1'b0;
    end else if (!i_run) begin
      cnt_ff <= 10'h000;
      o_tick <= 1'b0;
    end else if (cnt_ff >= half_w - 10'h001) begin
      cnt_ff <= 10'h000;
      o_tick <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 10'h001;
      o_tick <= 1'b0;
    end
  end
endmodule

// ### design/sync_serial_unit.sv
/*
 * Clocked synchronous serial unit: Avalon-MM register slave, shift engine for master
 * and slave roles, double-buffered receive and buffered transmit.
 * Assumes one 200 MHz clock; pins from the peer pass a two-flop synchroniser.
 */
`timescale 1ns/1ps
module sync_serial_unit import sync_serial_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  output logic [31:0] o_readdata,
  output logic o_waitrequest,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe_n,
  input wire logic i_sdi,
  output logic o_sdo
);
  typedef enum logic [1:0] {IDLE, SHIFT, DONE} shift_state_t;

  // bit reversal used on load
  function automatic logic [7:0] rev8(input logic [7:0] d);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < BITS_PER_BYTE; k++) begin
      r[k] = d[7 - k];
    end
    return r;
  endfunction

  unit_cfg_t cfg_w;
  logic [7:0] role_ff, order_rate_ff, dir_en_ff, rx_hold_ff, tx_hold_ff, shift_ff;
  logic [1:0] mode_ff;
  logic halt_rel_ff;
  logic rx_full_ff, overrun_ff, tx_end_ff, tx_empty_ff;
  logic rx_full_seen_ff, overrun_seen_ff, tx_end_seen_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  pin_in_t sync1_ff, sync2_ff;
  logic sck_last_ff;
  shift_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic sck_lvl_ff;
  logic sdo_ff;
  logic rx_stopped_ff;
  logic tick_w;

  // configuration view of the control registers
  assign cfg_w.master = role_ff[ROLE_MASTER_BIT];
  assign cfg_w.clk_out_en = role_ff[ROLE_CLKPIN_BIT];
  assign cfg_w.msb_first = order_rate_ff[ORDER_BIT];
  assign cfg_w.rate = order_rate_ff[2:0];
  assign cfg_w.tx_en = dir_en_ff[EN_TX_BIT];
  assign cfg_w.rx_en = dir_en_ff[EN_RX_BIT] & ~rx_stopped_ff;
  assign cfg_w.single_stop = dir_en_ff[EN_SSTOP_BIT];
  // standby until released, and only clocked synchronous mode runs
  assign cfg_w.run = halt_rel_ff & (mode_ff == MODE_CLOCKED_SYNC);

  // bus decode: one access takes one wait cycle, answered at the next edge
  wire acc_w = (i_read | i_write) & ~ack_ff;
  wire wr_w = i_write & ack_ff;
  wire rd_w = i_read & ack_ff;
  wire wr_role_w = wr_w & (i_address == ADDR_ROLE);
  wire wr_mode_w = wr_w & (i_address == ADDR_MODE);
  wire wr_or_w = wr_w & (i_address == ADDR_ORDER_RATE);
  wire wr_en_w = wr_w & (i_address == ADDR_DIR_EN);
  wire wr_flags_w = wr_w & (i_address == ADDR_FLAGS);
  wire wr_tx_w = wr_w & (i_address == ADDR_TX_HOLD);
  wire wr_halt_w = wr_w & (i_address == ADDR_CLK_HALT);
  wire rd_flags_w = rd_w & (i_address == ADDR_FLAGS);
  wire rd_rx_w = rd_w & (i_address == ADDR_RX_HOLD);


  // pin synchronisers; only the second stage is looked at
  // the stages reset to the idle-high level of the lines, so that the release of
  // reset cannot be mistaken for a rising clock edge in slave role
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_ff <= '{sck: 1'b1, sdi: 1'b1};
      sync2_ff <= '{sck: 1'b1, sdi: 1'b1};
      sck_last_ff <= 1'b1;
    end else begin
      sync1_ff <= '{sck: i_sck, sdi: i_sdi};
      sync2_ff <= sync1_ff;
      sck_last_ff <= sync2_ff.sck;
    end
  end

  rate_divider u_div (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    // kept running through the hand-over cycle so that a chained byte keeps the
    // clock rhythm; it stops only once the engine falls back to idle
    .i_run(cfg_w.run & cfg_w.master & ((state_ff == SHIFT) | (state_ff == DONE))),
    .i_rate(cfg_w.rate),
    .o_tick(tick_w)
  );

  // clock edges: master uses its own level, slave follows the synchronised pin
  wire rise_w = cfg_w.master ? (tick_w & ~sck_lvl_ff) : (sync2_ff.sck & ~sck_last_ff);
  wire fall_w = cfg_w.master ? (tick_w & sck_lvl_ff) : (~sync2_ff.sck & sck_last_ff);

  // transfers start when a direction has work: tx data pending, or master/slave reception
  wire tx_go_w = cfg_w.tx_en & ~tx_empty_ff & ~(overrun_ff & cfg_w.master);
  wire rx_go_w = cfg_w.rx_en & ~overrun_ff;
  wire start_w = cfg_w.run & (tx_go_w | rx_go_w) & (state_ff == IDLE);
  wire last_w = (state_ff == SHIFT) & rise_w & (bit_cnt_ff == 3'(BITS_PER_BYTE - 1));
  wire [7:0] load_w = cfg_w.msb_first ? rev8(tx_hold_ff) : tx_hold_ff;
  wire [7:0] shifted_w = {sync2_ff.sdi, shift_ff[7:1]};
  wire rx_byte_w = last_w & cfg_w.rx_en;
  wire rx_ok_w = rx_byte_w & ~rx_full_ff & ~overrun_ff;
  wire rx_ovr_w = rx_byte_w & rx_full_ff;

  // back-to-back continuation when the next byte is already waiting
  // judged in the hand-over cycle, when overrun and single stop of the byte just
  // finished are already visible, so neither can start one byte too many
  wire chain_w = (state_ff == DONE) & cfg_w.run & (tx_go_w | rx_go_w);

  // limitation: in master role the peer's data bit passes the two-flop
  // synchroniser, so it must settle within one half period less three cycles

  // shift engine; shift register only reached through holding registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= IDLE;
      shift_ff <= RESET_BYTE;
      bit_cnt_ff <= 3'h0;
      sck_lvl_ff <= 1'b1;
      sdo_ff <= 1'b1;
    end else if (!cfg_w.run) begin
      state_ff <= IDLE;
      bit_cnt_ff <= 3'h0;
      sck_lvl_ff <= 1'b1;
    end else begin
      case (state_ff)
        IDLE: begin
          if (start_w) begin
            shift_ff <= load_w;
            sdo_ff <= load_w[0];
            bit_cnt_ff <= 3'h0;
            state_ff <= SHIFT;
          end
        end
        SHIFT: begin
          if (cfg_w.master && tick_w) begin
            sck_lvl_ff <= ~sck_lvl_ff;
          end
          if (fall_w && bit_cnt_ff != 3'h0) begin
            sdo_ff <= shift_ff[0];
          end
          if (rise_w) begin
            shift_ff <= shifted_w; // sample on rising edge
            bit_cnt_ff <= bit_cnt_ff + 3'h1;
            if (last_w) begin
              state_ff <= DONE;
            end
          end
        end
        DONE: begin
          // shift register free again for the next byte
          if (chain_w) begin
            shift_ff <= load_w;
            bit_cnt_ff <= 3'h0;
            state_ff <= SHIFT;
          end else begin
            state_ff <= IDLE;
          end
          // first bit of the chained byte goes out in the hand-over cycle, before the next falling edge
          sdo_ff <= load_w[0];
        end
        default: state_ff <= IDLE;
      endcase
    end
  end

  // holding registers and flags; hardware set wins over software clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_hold_ff <= RESET_BYTE;
      tx_hold_ff <= RESET_BYTE;
      tx_empty_ff <= 1'b1;
      rx_full_ff <= 1'b0;
      overrun_ff <= 1'b0;
      tx_end_ff <= 1'b0;
      rx_full_seen_ff <= 1'b0;
      overrun_seen_ff <= 1'b0;
      tx_end_seen_ff <= 1'b0;
      rx_stopped_ff <= 1'b0;
    end else begin
      if (wr_tx_w) begin
        tx_hold_ff <= i_writedata[7:0];
      end
      if (start_w && tx_go_w) begin
        tx_empty_ff <= 1'b1;
      end else if (chain_w && tx_go_w) begin
        tx_empty_ff <= 1'b1;
      end else if (wr_tx_w) begin
        tx_empty_ff <= 1'b0;
      end
      if (rx_ok_w) begin
        rx_hold_ff <= shifted_w;
      end
      // remember a read of 1 so that a later write of 0 may clear
      if (rd_flags_w) begin
        rx_full_seen_ff <= rx_full_ff;
        overrun_seen_ff <= overrun_ff;
        tx_end_seen_ff <= tx_end_ff;
      end
      if (rx_ok_w) begin
        rx_full_ff <= 1'b1;
      end else if (rd_rx_w || (wr_flags_w && rx_full_seen_ff &&
                   !i_writedata[FLAG_RX_FULL_BIT])) begin
        rx_full_ff <= 1'b0;
      end
      if (rx_ovr_w) begin
        overrun_ff <= 1'b1; // new byte dropped
      end else if (wr_flags_w && overrun_seen_ff && !i_writedata[FLAG_OVERRUN_BIT]) begin
        overrun_ff <= 1'b0;
      end
      if (last_w && cfg_w.tx_en && tx_empty_ff) begin
        tx_end_ff <= 1'b1;
      end else if (wr_tx_w || (wr_flags_w && tx_end_seen_ff &&
                   !i_writedata[FLAG_TX_END_BIT])) begin
        tx_end_ff <= 1'b0;
      end
      // single-stop: reception ends after one byte until re-enabled
      if (rx_byte_w && cfg_w.single_stop) begin
        rx_stopped_ff <= 1'b1;
      end else if (wr_en_w) begin
        rx_stopped_ff <= 1'b0;
      end
    end
  end


  // control registers
  // software may rewrite them at any time; a change takes effect at the next edge
  // and is not held back until the byte in flight has finished
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      role_ff <= RESET_BYTE;
      mode_ff <= 2'h0;
      order_rate_ff <= RESET_BYTE;
      dir_en_ff <= RESET_BYTE;
      halt_rel_ff <= 1'b0; // standby after reset
    end else begin
      if (wr_role_w) role_ff <= i_writedata[7:0];
      if (wr_mode_w) mode_ff <= i_writedata[1:0];
      if (wr_or_w) order_rate_ff <= i_writedata[7:0];
      if (wr_en_w) dir_en_ff <= i_writedata[7:0];
      if (wr_halt_w) halt_rel_ff <= i_writedata[HALT_RELEASE_BIT];
    end
  end

  // read mux; receive holding has no write path shift register no address
  wire [7:0] flags_w = 8'({overrun_ff, 1'b0, 1'b0, tx_end_ff, tx_empty_ff, 1'b0,
                           rx_full_ff, 1'b0} >> 1) | 8'(overrun_ff) << FLAG_OVERRUN_BIT;
  logic [7:0] rsel_w;
  always_comb begin
    case (i_address)
      ADDR_ROLE: rsel_w = role_ff;
      ADDR_MODE: rsel_w = {6'h00, mode_ff};
      ADDR_ORDER_RATE: rsel_w = order_rate_ff;
      ADDR_DIR_EN: rsel_w = dir_en_ff;
      ADDR_FLAGS: rsel_w = 8'((8'(overrun_ff) << FLAG_OVERRUN_BIT) |
                              (8'(tx_end_ff) << FLAG_TX_END_BIT) |
                              (8'(tx_empty_ff) << FLAG_TX_EMPTY_BIT) |
                              (8'(rx_full_ff) << FLAG_RX_FULL_BIT));
      ADDR_RX_HOLD: rsel_w = rx_hold_ff;
      ADDR_TX_HOLD: rsel_w = tx_hold_ff;
      ADDR_CLK_HALT: rsel_w = {7'h00, halt_rel_ff};
      default: rsel_w = UNMAPPED_DATA[7:0];
    endcase
  end


  // bus handshake: waitrequest drops for one cycle per access
  // the ack flop blocks a second take of the same request in the answering cycle;
  // an access still held after the answering edge is taken again as a new access
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= UNMAPPED_DATA;
    end else begin
      ack_ff <= acc_w;
      if (acc_w && i_read) begin
        rdata_ff <= {24'h000000, rsel_w};
      end
    end
  end


  // outputs straight from flops; pin drive only when master with clock output selected
  // the extra register stage delays clock and data alike, so their relation holds
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sck <= 1'b1;
      o_sck_oe_n <= 1'b1;
      o_sdo <= 1'b1;
    end else begin
      o_sck <= sck_lvl_ff;
      o_sck_oe_n <= ~(cfg_w.run & cfg_w.master & cfg_w.clk_out_en);
      o_sdo <= sdo_ff;
    end
  end

  assign o_readdata = rdata_ff;
  assign o_waitrequest = ~ack_ff;

  wire unused_w = ^flags_w;
endmodule

// ### tb/sync_serial_unit_props.sv
/*
 * Port-level assertions for the clocked synchronous serial unit.
 * Assumes one clock domain and the register map of the package.
 */
`timescale 1ns/1ps
module sync_serial_unit_checker import sync_serial_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [5:0] i_address,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_writedata,
  input wire logic [31:0] o_readdata,
  input wire logic o_waitrequest,
  input wire logic o_sck,
  input wire logic o_sck_oe_n,
  input wire logic o_sdo
);
  logic released_ff;
  logic [2:0] rate_ff;
  wire wr_done = i_write && !o_waitrequest;
  // mirror of standby release and rate, so timing checks know what software set
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      released_ff <= 1'b0;
      rate_ff <= 3'h0;
    end else if (wr_done && i_address == ADDR_CLK_HALT) begin
      released_ff <= i_writedata[HALT_RELEASE_BIT];
    end else if (wr_done && i_address == ADDR_ORDER_RATE) begin
      rate_ff <= i_writedata[2:0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  bus_ack_a: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
    else $error("access not answered after one wait");
  ack_pulse_a: assert property (!o_waitrequest |=> o_waitrequest)
    else $error("acknowledge longer than one cycle");
  unmapped_zero_a: assert property (i_read && !o_waitrequest && i_address[5] |-> o_readdata == UNMAPPED_DATA)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (i_read && !o_waitrequest |-> o_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  standby_idle_a: assert property (!released_ff |-> o_sck && o_sdo && o_sck_oe_n)
    else $error("pins active in standby");
  master_drive_a: assert property ($fell(o_sck) |-> !o_sck_oe_n)
    else $error("clock toggles without drive");
  half_period_a: assert property ($fell(o_sck) && rate_ff == RATE_DIV8 |-> !o_sck [*4] ##1 o_sck)
    else $error("clock half period wrong");
  sdo_setup_a: assert property ($rose(o_sck) |-> $stable(o_sdo))
    else $error("data moves on sampling edge");
endmodule
bind sync_serial_unit sync_serial_unit_checker sync_serial_unit_checker_i (.i_clk(i_clk),
  .i_rst_n(i_rst_n), .i_address(i_address), .i_read(i_read), .i_write(i_write),
  .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
  .o_sck(o_sck), .o_sck_oe_n(o_sck_oe_n), .o_sdo(o_sdo));

// ### tb/serial_peer_model.sv
/*
 * Behavioural peer on the serial pins: follows the unit's clock or makes its own.
 * Assumes the unit's pins arrive as plain levels on the same system clock.
 */
`timescale 1ns/1ps
module serial_peer_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_sdo,
  input wire logic i_lead,
  input wire logic i_go,
  input wire logic [7:0] i_tx_byte,
  output logic o_sck,
  output logic o_sdi,
  output logic [7:0] o_rx_byte,
  output logic [7:0] o_rx_count
);
  logic [7:0] rx_ff;
  logic [2:0] bit_ff;
  logic [4:0] edges_ff;
  logic [2:0] div_ff;
  logic line_ff;
  wire line = i_lead ? o_sck : i_sck;
  // next bit presented as soon as the previous one is taken, leaving the unit's
  // synchroniser a whole half period; bit 0 stands while the link is idle
  assign o_sdi = i_tx_byte[bit_ff];
  // own clock, 8 cycles a half period: margin for the unit's pin synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sck <= 1'b1;
      edges_ff <= 5'h00;
      div_ff <= 3'h0;
    end else if (i_go) begin
      edges_ff <= 5'h10;
    end else if (edges_ff != 5'h00) begin
      div_ff <= div_ff + 3'h1;
      if (div_ff == 3'h7) begin
        o_sck <= ~o_sck;
        edges_ff <= edges_ff - 5'h01;
      end
    end
  end
  // bit in on rising edge, next bit out on the same edge; first bit lands in bit 0
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_ff <= 1'b1;
      bit_ff <= 3'h0;
      rx_ff <= 8'h00;
      o_rx_byte <= 8'h00;
      o_rx_count <= 8'h00;
    end else begin
      line_ff <= line;
      if (!line_ff && line) begin
        rx_ff[bit_ff] <= i_sdo;
        bit_ff <= bit_ff + 3'h1;
      end
      if (!line_ff && line && bit_ff == 3'h7) begin
        o_rx_byte <= {i_sdo, rx_ff[6:0]};
        o_rx_count <= o_rx_count + 8'h01;
      end
    end
  end
endmodule

// ### tb/testbench.sv
/*
 * Self-checking bench for the serial unit: registers over Avalon-MM, peer on the pins.
 * Assumes the package register map and a single 200 MHz clock.
 */
`timescale 1ns/1ps
module testbench import sync_serial_pkg::*; ();
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [5:0] address = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic lead = 1'b0;
  logic go = 1'b0;
  logic [7:0] peer_tx = 8'hc5;
  logic [31:0] rdata;
  logic waitreq, dev_sck, dev_oe_n, dev_sdo, peer_sck, peer_sdi;
  logic [7:0] peer_rx, peer_cnt;
  int checked = 0;
  int miscompares = 0;
  time t1, t2;
  always #2.5 i_clk = ~i_clk;
  sync_serial_unit sync_serial_unit_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_address(address),
    .i_read(rd), .i_write(wr), .i_writedata(wdata), .o_readdata(rdata),
    .o_waitrequest(waitreq), .i_sck(peer_sck), .o_sck(dev_sck), .o_sck_oe_n(dev_oe_n),
    .i_sdi(peer_sdi), .o_sdo(dev_sdo));
  serial_peer_model serial_peer_model_i (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sck(dev_sck),
    .i_sdo(dev_sdo), .i_lead(lead), .i_go(go), .i_tx_byte(peer_tx), .o_sck(peer_sck),
    .o_sdi(peer_sdi), .o_rx_byte(peer_rx), .o_rx_count(peer_cnt));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one access: hold everything until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge i_clk);
    address <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge i_clk);
      n++;
    end while (waitreq !== 1'b0 && n < 64);
    q = rdata[7:0];
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 64) miscompares++;
  endtask
  task automatic put(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic get(input string what, input logic [5:0] a, input logic [7:0] m,
                     input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check(what, q & m, exp);
  endtask
  // bounded wait, so a stuck link cannot hang the run
  task automatic wait_peer(input logic [7:0] n);
    int k;
    k = 0;
    while (peer_cnt !== n && k < 4000) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 4000) miscompares++;
  endtask
  task automatic peer_send(input logic [7:0] b);
    @(posedge i_clk);
    lead <= 1'b1;
    peer_tx <= b;
    go <= 1'b1;
    @(posedge i_clk);
    go <= 1'b0;
  endtask
  task automatic t_standby();
    get("rx hold reset", ADDR_RX_HOLD, 8'hff, RESET_BYTE);
    get("tx hold reset", ADDR_TX_HOLD, 8'hff, RESET_BYTE);
    put(ADDR_RX_HOLD, 8'ha5);
    get("rx hold write", ADDR_RX_HOLD, 8'hff, RESET_BYTE);
    get("unmapped", 6'h20, 8'hff, 8'h00);
    put(ADDR_ROLE, 8'h60);
    put(ADDR_MODE, {6'h0, MODE_CLOCKED_SYNC});
    put(ADDR_ORDER_RATE, {5'h0, RATE_DIV8});
    put(ADDR_DIR_EN, 8'hc0);
    put(ADDR_TX_HOLD, 8'h5a);
    get("tx hold write", ADDR_TX_HOLD, 8'hff, 8'h5a);
    repeat (100) @(posedge i_clk);
    check("standby bytes", peer_cnt, 8'h00);
    $display("test standby done");
  endtask
  task automatic t_master();
    put(ADDR_CLK_HALT, 8'h01);
    put(ADDR_TX_HOLD, 8'h3c);
    wait_peer(8'h01);
    t1 = $time;
    check("first byte", peer_rx, 8'h5a);
    wait_peer(8'h02);
    t2 = $time;
    check("second byte", peer_rx, 8'h3c);
    check("byte spacing", 8'((t2 - t1) / 5), 8'h40);
    repeat (20) @(posedge i_clk);
    get("flags set", ADDR_FLAGS, 8'h4a, 8'h4a);
    get("kept byte", ADDR_RX_HOLD, 8'hff, 8'hc5);
    get("full by read", ADDR_FLAGS, 8'h02, 8'h00);
    put(ADDR_DIR_EN, 8'h00);
    put(ADDR_FLAGS, 8'h08);
    get("overrun clear", ADDR_FLAGS, 8'h48, 8'h08);
    $display("test master done");
  endtask
  task automatic t_msb();
    put(ADDR_ORDER_RATE, 8'h81);
    put(ADDR_TX_HOLD, 8'h01);
    get("end by data", ADDR_FLAGS, 8'h08, 8'h00);
    repeat (100) @(posedge i_clk);
    check("tx disabled", peer_cnt, 8'h02);
    put(ADDR_DIR_EN, 8'h80);
    wait_peer(8'h03);
    check("msb byte", peer_rx, 8'h80);
    repeat (20) @(posedge i_clk);
    get("tx only flags", ADDR_FLAGS, 8'h4a, 8'h08);
    $display("test msb done");
  endtask
  task automatic t_slave();
    put(ADDR_ROLE, 8'h00);
    put(ADDR_ORDER_RATE, {5'h0, RATE_DIV8});
    put(ADDR_DIR_EN, 8'h60);
    peer_send(8'h6b);
    wait_peer(8'h04);
    check("pin released", {7'h0, dev_oe_n}, 8'h01);
    repeat (20) @(posedge i_clk);
    get("slave byte", ADDR_RX_HOLD, 8'hff, 8'h6b);
    get("full cleared", ADDR_FLAGS, 8'h02, 8'h00);
    peer_send(8'h11);
    wait_peer(8'h05);
    repeat (20) @(posedge i_clk);
    get("single stop", ADDR_FLAGS, 8'h42, 8'h00);
    get("hold kept", ADDR_RX_HOLD, 8'hff, 8'h6b);
    $display("test slave done");
  endtask
  task automatic complete_run();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_standby();
    t_master();
    t_msb();
    t_slave();
    complete_run();
  end
  // watchdog, well beyond the thousand or so cycles the tests need
  initial begin
    repeat (20000) @(posedge i_clk);
    miscompares++;
    complete_run();
  end
endmodule
